// ---- inc/sefl_pkg.sv ----
// Purpose: Shared constants and types for status and event flag logic
// Assumes: 32-bit AHB-Lite register bus, word aligned
// Notes:   Offsets are byte addresses
package sefl_pkg;
  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] A_CTRL  = 8'h00;
  localparam logic [7:0] A_VBAND = 8'h04;
  localparam logic [7:0] A_IBAND = 8'h08;
  localparam logic [7:0] A_TEMP  = 8'h0C;
  localparam logic [7:0] A_COND  = 8'h10;
  localparam logic [7:0] A_EVT   = 8'h14;
  localparam logic [7:0] A_EN    = 8'h18;
  localparam logic [7:0] A_EDGE  = 8'h1C;

  // Control register bits
  localparam int C_TRACK  = 0;
  localparam int C_RECALL = 1;
  localparam int C_ON     = 2;
  localparam int C_OPC    = 3;

  // Condition bits
  localparam int CB_VBAND = 0;
  localparam int CB_IBAND = 1;
  localparam int CB_LLOW  = 2;
  localparam int CB_VREG  = 3;
  localparam int CB_IREG  = 4;
  localparam int CB_OVLD  = 5;
  localparam int CB_OTPW  = 6;
  localparam int CB_OTPS  = 7;
  localparam int CB_FAULT = 8;
  localparam int CB_OUTON = 9;
  localparam int CB_MAV   = 10;

  // Event bits
  localparam int EB_VBAND = 0;
  localparam int EB_IBAND = 1;
  localparam int EB_LIMIT = 2;
  localparam int EB_CMDE  = 3;
  localparam int EB_EXEC  = 4;
  localparam int EB_LINE  = 5;
  localparam int EB_VREG  = 6;
  localparam int EB_IREG  = 7;
  localparam int EB_OVLD  = 8;
  localparam int EB_OTPW  = 9;
  localparam int EB_OTPS  = 10;
  localparam int EB_OTPC  = 11;
  localparam int EB_OCP   = 12;
  localparam int EB_OUTPUT_ENABLE_ERROR  = 13;
  localparam int EB_OPC   = 14;
  localparam int EB_FAULT = 15;

  // Event bits taken from transitions of a level
  localparam logic [15:0] EV_LEVEL_MASK = 16'h87C3;

  // Thresholds and codes
  localparam logic [9:0]  LINE_LOW_VRMS = 10'h0B6; // 182 V rms
  localparam logic [8:0]  OTP_DELTA     = 9'h005;  // 5 degC
  localparam logic [7:0]  ERR_OUTPUT_ENABLE_ERROR      = 8'h49;   // 73
  localparam logic [15:0] BAND_FLOOR_RST = 16'h0000;
  localparam logic [15:0] BAND_CEIL_RST  = 16'hFFFF;
  localparam logic [7:0]  TWARN_RST     = 8'h50;

  // Measurement inputs
  typedef struct packed {
    logic [15:0] volt;
    logic [15:0] curr;
    logic [7:0]  temp;
    logic [9:0]  line_vrms;
  } sefl_meas_t;

  // Error pulses from command handling
  typedef struct packed {
    logic cmd_syntax;
    logic param_conflict;
    logic setpoint_range;
    logic meas_over;
    logic seq_limit;
  } sefl_err_t;

  // All state of the block
  typedef struct packed {
    logic [1:0]  trig_sync;
    logic        track;
    logic        recall;
    logic [15:0] vfloor;
    logic [15:0] vceil;
    logic [15:0] ifloor;
    logic [15:0] iceil;
    logic [7:0]  twarn;
    logic [15:0] evt;
    logic [15:0] ev_en;
    logic [15:0] edge_fall;
    logic [15:0] lvl_prev;
    logic        line_prev;
    logic        otp_prev;
    logic        out_on;
    logic        opc_pend;
    logic [7:0]  err_code;
    logic        dp_wr;
    logic [7:0]  dp_addr;
    logic [31:0] rdata;
    logic [15:0] cond_out;
  } sefl_state_t;
endpackage

// ---- design/sefl_status_flags.sv ----
// Purpose: Status condition and event flags of a power supply
// Assumes: Sources other than the trigger pin are on hclk
// Notes:   Zero wait state AHB-Lite slave
// Function
// - Flag each mains range change
// - Line low while mains below 182 V
// - Voltage outside band when tracking on
// - Current outside band when tracking on
// - Record band events when tracking on
// - Voltage and current regulating mode flags
// - Command error on bad command or syntax
// - Execution error on parameter or state conflict
// - Limit error on setpoint, measurement, sequence
// - Message available when response is waiting
// - Overcurrent trip flags, output off until on
// - Overload flag when power limiting triggers
// - Operation complete after preceding commands finish
// - Warning, then shutdown 5 degC higher
// - Shutdown ignores switch on, sets event
// - Cooled flag; recall restarts output
// - Output error and code 73 when blocked
// - Internal fault flag while error pending
// - Condition bits read only, one is true
// - Events latch on transition, clear on read
// - Summary while any enabled event set
//
// Register access over AHB-Lite and the register addresses were left to the implementer.
`timescale 1ns/1ps
module sefl_status_flags
  import sefl_pkg::*;
(
  // Clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // Device sources
  input  wire sefl_meas_t  meas,
  input  wire sefl_err_t   err,
  input  wire logic        volt_reg,
  input  wire logic        curr_reg,
  input  wire logic        power_limit,
  input  wire logic        ocp_trip,
  input  wire logic        hw_block,
  input  wire logic        ext_off_trig,
  input  wire logic        fault_pending,
  input  wire logic        resp_waiting,
  input  wire logic        cmd_busy,
  // Status outputs
  output logic             output_on,
  output logic             group_summary,
  output logic      [7:0]  error_code,
  output logic      [15:0] cond_flags
);

  sefl_state_t q;
  sefl_state_t d;

  logic        vcond;
  logic        icond;
  logic        llow;
  logic        otp_warn;
  logic        otp_shut;
  logic        blocked;
  logic        acc;
  logic        on_cmd;
  logic        opc_cmd;
  logic        rd_evt;
  logic        cooled;
  logic        opc_done;
  logic [15:0] cond;
  logic [15:0] lvl;
  logic [15:0] edges;
  logic [15:0] pulse;
  logic [15:0] set;

  // ----------------------------------------------------------------
  // Conditions
  // ----------------------------------------------------------------
  assign vcond    = q.track & (meas.volt < q.vfloor | meas.volt > q.vceil);
  assign icond    = q.track & (meas.curr < q.ifloor | meas.curr > q.iceil);
  assign llow     = meas.line_vrms < LINE_LOW_VRMS;
  assign otp_warn = meas.temp >= q.twarn;
  assign otp_shut = {1'b0, meas.temp} >= ({1'b0, q.twarn} + OTP_DELTA);
  assign blocked  = hw_block | q.trig_sync[1];
  assign cooled   = q.otp_prev & ~otp_shut;

  always_comb begin
    cond           = '0;
    cond[CB_VBAND] = vcond;
    cond[CB_IBAND] = icond;
    cond[CB_LLOW]  = llow;
    cond[CB_VREG]  = volt_reg;
    cond[CB_IREG]  = curr_reg;
    cond[CB_OVLD]  = power_limit;
    cond[CB_OTPW]  = otp_warn;
    cond[CB_OTPS]  = otp_shut;
    cond[CB_FAULT] = fault_pending;
    cond[CB_OUTON] = q.out_on;
    cond[CB_MAV]   = resp_waiting;
  end

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  assign acc      = hsel & htrans[1] & hready;
  assign rd_evt   = acc & ~hwrite & (haddr[7:0] == A_EVT);
  assign on_cmd   = q.dp_wr & (q.dp_addr == A_CTRL) & hwdata[C_ON];
  assign opc_cmd  = q.dp_wr & (q.dp_addr == A_CTRL) & hwdata[C_OPC];
  assign opc_done = q.opc_pend & ~cmd_busy;

  // ----------------------------------------------------------------
  // Event sources
  // ----------------------------------------------------------------
  always_comb begin
    lvl           = '0;
    lvl[EB_VBAND] = vcond;
    lvl[EB_IBAND] = icond;
    lvl[EB_VREG]  = volt_reg;
    lvl[EB_IREG]  = curr_reg;
    lvl[EB_OVLD]  = power_limit;
    lvl[EB_OTPW]  = otp_warn;
    lvl[EB_OTPS]  = otp_shut;
    lvl[EB_FAULT] = fault_pending;
    edges = ((lvl & ~q.lvl_prev & ~q.edge_fall) | (~lvl & q.lvl_prev & q.edge_fall)) & EV_LEVEL_MASK;
    pulse           = '0;
    pulse[EB_LINE]  = q.line_prev ^ llow;
    pulse[EB_CMDE]  = err.cmd_syntax;
    pulse[EB_EXEC]  = err.param_conflict;
    pulse[EB_LIMIT] = err.setpoint_range | err.meas_over | err.seq_limit;
    pulse[EB_OCP]   = ocp_trip & q.out_on;
    pulse[EB_OTPS]  = on_cmd & otp_shut;
    pulse[EB_OTPC]  = cooled;
    pulse[EB_OUTPUT_ENABLE_ERROR]  = on_cmd & ~otp_shut & blocked;
    pulse[EB_OPC]   = opc_done;
    set = edges | pulse;
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    d           = q;
    d.trig_sync = {q.trig_sync[0], ext_off_trig};
    d.lvl_prev  = lvl;
    d.line_prev = llow;
    d.otp_prev  = otp_shut;
    d.cond_out  = cond;
    // Set wins over clear on read
    d.evt = rd_evt ? set : (q.evt | set);
    // Output switching
    if (ocp_trip | otp_shut) begin
      d.out_on = 1'b0;
    end else if (on_cmd & ~blocked) begin
      d.out_on = 1'b1;
    end else if (cooled & q.recall & ~blocked) begin
      d.out_on = 1'b1;
    end
    if (pulse[EB_OUTPUT_ENABLE_ERROR]) begin
      d.err_code = ERR_OUTPUT_ENABLE_ERROR;
    end
    if (opc_done) begin
      d.opc_pend = 1'b0;
    end
    if (opc_cmd) begin
      d.opc_pend = 1'b1;
    end
    // Data phase writes
    if (q.dp_wr) begin
      if (q.dp_addr == A_CTRL) begin
        d.track  = hwdata[C_TRACK];
        d.recall = hwdata[C_RECALL];
      end else if (q.dp_addr == A_VBAND) begin
        d.vfloor = hwdata[15:0];
        d.vceil  = hwdata[31:16];
      end else if (q.dp_addr == A_IBAND) begin
        d.ifloor = hwdata[15:0];
        d.iceil  = hwdata[31:16];
      end else if (q.dp_addr == A_TEMP) begin
        d.twarn = hwdata[7:0];
      end else if (q.dp_addr == A_EN) begin
        d.ev_en = hwdata[15:0];
      end else if (q.dp_addr == A_EDGE) begin
        d.edge_fall = hwdata[15:0];
      end
    end
    // Address phase capture and read data
    d.dp_wr   = acc & hwrite;
    d.dp_addr = haddr[7:0];
    d.rdata   = '0;
    if (acc & ~hwrite) begin
      if (haddr[7:0] == A_CTRL) begin
        d.rdata = {28'h000_0000, q.opc_pend, 1'b0, q.recall, q.track};
      end else if (haddr[7:0] == A_VBAND) begin
        d.rdata = {q.vceil, q.vfloor};
      end else if (haddr[7:0] == A_IBAND) begin
        d.rdata = {q.iceil, q.ifloor};
      end else if (haddr[7:0] == A_TEMP) begin
        d.rdata = {24'h00_0000, q.twarn};
      end else if (haddr[7:0] == A_COND) begin
        d.rdata = {16'h0000, cond};
      end else if (haddr[7:0] == A_EVT) begin
        d.rdata = {16'h0000, q.evt};
      end else if (haddr[7:0] == A_EN) begin
        d.rdata = {16'h0000, q.ev_en};
      end else if (haddr[7:0] == A_EDGE) begin
        d.rdata = {16'h0000, q.edge_fall};
      end
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      q        <= '0;
      q.vfloor <= BAND_FLOOR_RST;
      q.vceil  <= BAND_CEIL_RST;
      q.ifloor <= BAND_FLOOR_RST;
      q.iceil  <= BAND_CEIL_RST;
      q.twarn  <= TWARN_RST;
    end else begin
      q <= d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign hrdata        = q.rdata;
  assign hreadyout     = 1'b1;
  assign hresp         = 1'b0;
  assign output_on     = q.out_on;
  assign error_code    = q.err_code;
  assign cond_flags    = q.cond_out;
  assign group_summary = |(q.evt & q.ev_en);

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  a_evt_read_clear: assert property (rd_evt && set == '0 |=> q.evt == '0)
    else $error("event register not cleared by read");
  a_ocp_output_off: assert property (ocp_trip |=> !q.out_on ##1 (!q.out_on || $past(on_cmd) || $past(cooled)))
    else $error("output on after overcurrent trip");
  a_shut_ignores_on: assert property (otp_shut && on_cmd |=> !q.out_on && q.evt[EB_OTPS])
    else $error("switch on not ignored in shutdown");
  a_blocked_code: assert property (on_cmd && blocked && !otp_shut |=> q.err_code == ERR_OUTPUT_ENABLE_ERROR && q.evt[EB_OUTPUT_ENABLE_ERROR])
    else $error("blocked switch on not flagged");
  a_track_off_band: assert property (!q.track |-> !cond[CB_VBAND] && !cond[CB_IBAND])
    else $error("band condition without tracking");
  a_opc_after_busy: assert property (q.opc_pend && cmd_busy |=> !q.evt[EB_OPC] || $past(q.evt[EB_OPC]))
    else $error("completion flagged while busy");
  a_opc_done_set: assert property (opc_done && !opc_cmd |=> q.evt[EB_OPC] && !q.opc_pend)
    else $error("completion not flagged");
  a_line_change: assert property ($changed(llow) |-> ##0 1 ##1 q.evt[EB_LINE])
    else $error("mains range change not flagged");
  a_cool_restart: assert property (cooled && q.recall && !blocked && !ocp_trip |=> q.out_on && q.evt[EB_OTPC])
    else $error("no restart after cooling");
  a_summary_mask: assert property (q.ev_en == '0 |-> !group_summary)
    else $error("summary with nothing enabled");

  // ----------------------------------------------------------------
  // Flag source assertions
  // ----------------------------------------------------------------
  a_vband_high: assert property (
    q.track && meas.volt > q.vceil |-> cond[CB_VBAND])
    else $error("voltage above band not flagged");

  a_iband_low: assert property (
    q.track && meas.curr < q.ifloor |-> cond[CB_IBAND])
    else $error("current below band not flagged");

  a_iband_high: assert property (
    q.track && meas.curr > q.iceil |-> cond[CB_IBAND])
    else $error("current above band not flagged");

  a_vband_event: assert property (
    $rose(vcond) && !q.edge_fall[EB_VBAND] |=> q.evt[EB_VBAND])
    else $error("voltage band event missing");

  a_iband_event: assert property (
    $rose(icond) && !q.edge_fall[EB_IBAND] |=> q.evt[EB_IBAND])
    else $error("current band event missing");

  a_line_low: assert property (
    cond[CB_LLOW] == (meas.line_vrms < LINE_LOW_VRMS))
    else $error("line low bit wrong");

  a_reg_modes: assert property (
    cond[CB_VREG] == volt_reg && cond[CB_IREG] == curr_reg)
    else $error("regulating mode bits wrong");

  a_vreg_event: assert property (
    $rose(volt_reg) && !q.edge_fall[EB_VREG] |=> q.evt[EB_VREG])
    else $error("voltage mode event missing");

  a_cmd_error: assert property (
    err.cmd_syntax |=> q.evt[EB_CMDE])
    else $error("command error not flagged");

  a_exec_error: assert property (
    err.param_conflict |=> q.evt[EB_EXEC])
    else $error("execution error not flagged");

  a_limit_error: assert property (
    err.setpoint_range || err.meas_over || err.seq_limit |=> q.evt[EB_LIMIT])
    else $error("limit error not flagged");

  a_msg_avail: assert property (
    cond[CB_MAV] == resp_waiting)
    else $error("message available bit wrong");

  a_ocp_event: assert property (
    ocp_trip && q.out_on |=> q.evt[EB_OCP])
    else $error("overcurrent trip not flagged");

  a_on_cmd: assert property (
    on_cmd && !blocked && !ocp_trip && !otp_shut |=> q.out_on)
    else $error("switch on not obeyed");

  a_overload_event: assert property (
    $rose(power_limit) && !q.edge_fall[EB_OVLD] |=> q.evt[EB_OVLD])
    else $error("overload event missing");

  a_otp_warn: assert property (
    meas.temp >= q.twarn |-> cond[CB_OTPW])
    else $error("temperature warning missing");

  a_shut_margin: assert property (
    otp_shut |-> otp_warn)
    else $error("shutdown below warning");

  a_shut_off: assert property (
    cond[CB_OTPS] |=> !q.out_on)
    else $error("output on in shutdown");

  a_blocked_stays_off: assert property (
    blocked && !q.out_on |=> !q.out_on)
    else $error("output on while blocked");

  a_fault_flag: assert property (
    cond[CB_FAULT] == fault_pending)
    else $error("fault bit wrong");

  a_cond_readback: assert property (
    acc && !hwrite && haddr[7:0] == A_COND |=> hrdata == {16'h0000, $past(cond)})
    else $error("condition read wrong");

  a_evt_write_kept: assert property (
    q.dp_wr && q.dp_addr == A_EVT && !rd_evt && set == '0 |=> q.evt == $past(q.evt))
    else $error("event register written");

  a_fall_select: assert property (
    $fell(volt_reg) && q.edge_fall[EB_VREG] |=> q.evt[EB_VREG])
    else $error("falling edge event missing");

  a_summary_cmd: assert property (
    q.evt[EB_CMDE] && q.ev_en[EB_CMDE] |-> group_summary)
    else $error("summary missing");

  a_reset_events: assert property (
    $rose(hresetn) |-> q.evt == '0 && q.err_code == '0 && !q.out_on)
    else $error("state not cleared by reset");

  a_cond_regd: assert property (
    $past(hresetn) |-> cond_flags == $past(cond))
    else $error("condition output not registered");

endmodule

// ---- tb/sefl_ahb_host.sv ----
// Purpose: AHB-Lite master standing in for the remote controller
// Assumes: One slave, single whole-word transfers
// Notes:   Signals change just after a rising edge
`timescale 1ns/1ps
module sefl_ahb_host (
  // Bus
  input  wire logic        hclk,
  input  wire logic        hready,
  input  wire logic [31:0] hrdata,
  output logic             hsel,
  output logic      [31:0] haddr,
  output logic      [1:0]  htrans,
  output logic             hwrite,
  output logic      [2:0]  hsize,
  output logic      [31:0] hwdata
);
  initial begin
    hsel   = 1'b0;
    haddr  = 32'h0000_0000;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize  = 3'h2;
    hwdata = 32'h0000_0000;
  end
  // Address phase held until hready, then data phase
  task automatic xfer(input logic w, input logic [31:0] a, d, output logic [31:0] r);
    @(posedge hclk);
    hsel   <= 1'b1;
    haddr  <= a;
    htrans <= 2'h2;
    hwrite <= w;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    htrans <= 2'h0;
    hwdata <= w ? d : ~hwdata;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    r = hrdata;
  endtask
endmodule

// ---- tb/tb_top.sv ----
// Purpose: Self-checking bench for the status and event flag block
// Assumes: Zero wait register bus, seed 47
// Notes:   Events cleared by a read before each case
`timescale 1ns/1ps
module tb_top
  import sefl_pkg::*;
;
  logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, output_on, group_summary;
  logic [31:0] haddr, hwdata, hrdata, rv;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [7:0]  error_code;
  logic [15:0] cond_flags, v, c, pv, pc;
  logic [4:0]  lv;
  logic        ocp_trip, hw_block, ext_off_trig, cmd_busy;
  sefl_meas_t  meas;
  sefl_err_t   err;
  int          miscompares, n_checks, seed;
  int          cb[5] = '{3, 4, 5, 8, 10};
  logic [15:0] eb[5] = '{16'h0040, 16'h0080, 16'h0100, 16'h8000, 16'h0000};
  logic [15:0] tb[4] = '{16'h0100, 16'h0200, 16'h00FF, 16'h0201};

  sefl_ahb_host sefl_ahb_host_i (.hclk(hclk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));
  sefl_status_flags sefl_status_flags_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .meas(meas), .err(err),
    .volt_reg(lv[0]), .curr_reg(lv[1]), .power_limit(lv[2]), .ocp_trip(ocp_trip),
    .hw_block(hw_block), .ext_off_trig(ext_off_trig), .fault_pending(lv[3]),
    .resp_waiting(lv[4]), .cmd_busy(cmd_busy), .output_on(output_on),
    .group_summary(group_summary), .error_code(error_code), .cond_flags(cond_flags));

  initial begin
    hclk = 1'b0;
    forever #10 hclk = ~hclk;
  end

  task automatic chk(input logic [31:0] got, exp, m, input string s);
    n_checks++;
    if ((got & m) !== exp) begin
      miscompares++;
      $display("CHECK FAILED %0t %s", $time, s);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    sefl_ahb_host_i.xfer(1'b1, {24'h00_0000, a}, d, x);
  endtask
  task automatic rd(input logic [7:0] a);
    sefl_ahb_host_i.xfer(1'b0, {24'h00_0000, a}, 32'h0000_0000, rv);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge hclk);
  endtask
  function automatic logic outb(logic [15:0] x, f, h);
    return (x < f) || (x > h);
  endfunction
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  initial begin
    #200_000;
    miscompares++;
    print_verdict();
  end

  initial begin
    seed = 47;
    hresetn = 1'b0;
    meas = '{volt: 16'h0150, curr: 16'h0100, temp: 8'h20, line_vrms: 10'h0E6};
    err = '0;
    lv = '0;
    {ocp_trip, hw_block, ext_off_trig, cmd_busy} = 4'h0;
    cyc(5);
    hresetn <= 1'b1;
    rd(A_VBAND); chk(rv, 32'hFFFF_0000, '1, "vband reset");
    rd(A_TEMP); chk(rv, 32'h0000_0050, '1, "temp reset");
    rd(8'h40); chk(rv, 32'h0000_0000, '1, "unmapped read");
    chk({31'h0, hresp}, 0, 1, "okay response");
    rd(A_EVT); chk(rv, 32'h0000_0000, '1, "events after reset");
    $display("reset test done");
    wr(A_CTRL, 32'h0000_0001);
    wr(A_VBAND, 32'h0200_0100);
    wr(A_IBAND, 32'h0200_0100);
    rd(A_EVT);
    {pv, pc} = '0;
    for (int i = 0; i < 12; i++) begin
      v = (i < 4) ? tb[i] : 16'($random(seed));
      c = (i < 4) ? tb[3 - i] : 16'($random(seed));
      meas.volt <= v;
      meas.curr <= c;
      cyc(2);
      chk({16'h0, cond_flags}, {30'h0, outb(c, 16'h0100, 16'h0200), outb(v, 16'h0100, 16'h0200)}, 3, "band");
      rd(A_EVT);
      chk(rv, {30'h0, outb(c, 16'h0100, 16'h0200) & ~pc[0], outb(v, 16'h0100, 16'h0200) & ~pv[0]}, 3, "band ev");
      pv = 16'(outb(v, 16'h0100, 16'h0200));
      pc = 16'(outb(c, 16'h0100, 16'h0200));
    end
    wr(A_CTRL, 32'h0000_0000);
    meas.volt <= 16'hF000;
    cyc(2);
    chk({16'h0, cond_flags}, 32'h0, 1, "tracking off");
    $display("band test done");
    meas.line_vrms <= 10'h0B5;
    cyc(2);
    chk({16'h0, cond_flags}, 32'h4, 32'h4, "line low");
    rd(A_EVT); chk(rv, 32'h20, 32'h20, "line drop");
    meas.line_vrms <= 10'h0B6;
    cyc(2);
    chk({16'h0, cond_flags}, 32'h0, 32'h4, "line ok");
    rd(A_EVT); chk(rv, 32'h20, 32'h20, "line rise");
    for (int i = 0; i < 5; i++) begin
      lv <= 5'(1 << i);
      cyc(2);
      chk({16'h0, cond_flags}, 32'(1 << cb[i]), 32'h0538, "level cond");
      rd(A_COND); chk(rv, 32'(1 << cb[i]), 32'h0538, "cond reg");
      rd(A_EVT); chk(rv, {16'h0, eb[i]}, 32'h81C0, "level ev");
    end
    lv <= '0;
    for (int i = 0; i < 5; i++) begin
      err <= sefl_err_t'(5'(1 << i));
      cyc(1);
      err <= '0;
      rd(A_EVT); chk(rv, (i == 4) ? 32'h8 : (i == 3) ? 32'h10 : 32'h4, 32'h1C, "error ev");
    end
    $display("flag test done");
    wr(A_CTRL, 32'h0000_0004);
    cyc(1);
    chk({31'h0, output_on}, 1, 1, "switch on");
    ocp_trip <= 1'b1;
    cyc(1);
    ocp_trip <= 1'b0;
    cyc(4);
    chk({31'h0, output_on}, 0, 1, "ocp off");
    rd(A_EVT); chk(rv, 32'h1000, 32'h1000, "ocp ev");
    hw_block <= 1'b1;
    wr(A_CTRL, 32'h0000_0004);
    cyc(1);
    chk({24'h0, error_code}, 32'h49, '1, "code 73");
    rd(A_EVT); chk(rv, 32'h2000, 32'h2000, "blocked ev");
    hw_block <= 1'b0;
    ext_off_trig <= 1'b1;
    cyc(3);
    wr(A_CTRL, 32'h0000_0004);
    chk({31'h0, output_on}, 0, 1, "trig block");
    rd(A_EVT); chk(rv, 32'h2000, 32'h2000, "trig ev");
    ext_off_trig <= 1'b0;
    cyc(3);
    wr(A_CTRL, 32'h0000_0006);
    meas.temp <= 8'h52;
    cyc(2);
    chk({16'h0, cond_flags}, 32'h40, 32'hC0, "warn");
    meas.temp <= 8'h56;
    cyc(2);
    chk({16'h0, cond_flags}, 32'hC0, 32'hC0, "shut");
    chk({31'h0, output_on}, 0, 1, "shut off");
    rd(A_EVT);
    wr(A_CTRL, 32'h0000_0006);
    chk({31'h0, output_on}, 0, 1, "on ignored");
    rd(A_EVT); chk(rv, 32'h400, 32'h400, "shut ev again");
    meas.temp <= 8'h20;
    cyc(3);
    chk({31'h0, output_on}, 1, 1, "recall restart");
    rd(A_EVT); chk(rv, 32'h800, 32'h800, "cooled ev");
    $display("output test done");
    cmd_busy <= 1'b1;
    wr(A_CTRL, 32'h0000_0008);
    cyc(3);
    rd(A_EVT); chk(rv, 32'h0, 32'h4000, "opc early");
    cmd_busy <= 1'b0;
    cyc(2);
    rd(A_EVT); chk(rv, 32'h4000, 32'h4000, "opc done");
    wr(A_EN, 32'h0000_0010);
    err <= '{cmd_syntax: 1'b1, default: 1'b0};
    cyc(1);
    err <= '0;
    cyc(1);
    chk({31'h0, group_summary}, 0, 1, "masked");
    wr(A_EN, 32'h0000_0008);
    cyc(1);
    chk({31'h0, group_summary}, 1, 1, "summary");
    rd(A_EVT);
    cyc(1);
    chk({31'h0, group_summary}, 0, 1, "summary clear");
    $display("summary test done");
    wr(A_EDGE, 32'h0000_0040);
    rd(A_EDGE); chk(rv, 32'h40, '1, "edge reg");
    lv <= 5'h01;
    cyc(2);
    rd(A_EVT); chk(rv, 32'h0, 32'h40, "rise ignored");
    lv <= 5'h00;
    cyc(2);
    rd(A_EVT); chk(rv, 32'h40, 32'h40, "fall taken");
    err <= '{cmd_syntax: 1'b1, default: 1'b0};
    cyc(1);
    err <= '0;
    hresetn <= 1'b0;
    cyc(2);
    hresetn <= 1'b1;
    rd(A_EVT); chk(rv, 32'h0, '1, "events after mid reset");
    rd(A_EDGE); chk(rv, 32'h0, '1, "edge after mid reset");
    chk({24'h0, error_code}, 0, '1, "code after mid reset");
    $display("edge and reset test done");
    print_verdict();
  end
endmodule
